//--- core/sfd_pkg.sv
// Purpose: Shared constants for the speaker fault diagnostic sequencer
// Assumes: 250 MHz clock, four output channels
// Notes:   Times kept in their own units; cycle counts derived here
package sfd_pkg;
    localparam int NCH            = 4;
    localparam int CLK_MHZ        = 250;
    // Timing
    localparam int RECHECK_US     = 1000;    // 1 ms recheck
    localparam int DIAG_CYCLE_US  = 100000;  // 100 ms diagnostic cycle / acquisition
    localparam int RECHECK_CYC    = RECHECK_US * CLK_MHZ;
    localparam int DIAG_CYC       = DIAG_CYCLE_US * CLK_MHZ;
    localparam int AC_MIN_PULSES  = 3;
    // Instruction byte fields
    localparam int IB1_DIAG_EN    = 6;
    localparam int IB1_OFFS_EN    = 5;
    localparam int IB1_GAIN_F     = 4;
    localparam int IB1_GAIN_R     = 3;
    localparam int IB2_STBY_OFF   = 4;
    localparam int IB2_LINE_DRV   = 3;
    localparam int IB2_AC_EN      = 2;
    // Result bit positions per channel byte
    localparam int RB_AC_OPEN     = 5;
    localparam int RB_PERM        = 4;
    localparam int RB_SHORT_LOAD  = 3;
    localparam int RB_OPEN_OFFS   = 2;
    localparam int RB_SHORT_VS    = 1;
    localparam int RB_SHORT_GND   = 0;
    localparam int FB1_DONE       = 6;
    localparam logic [7:0] IB_RST = 8'h00;
endpackage : sfd_pkg

//--- core/sfd_seq.sv
// Purpose: Fault diagnostic sequencing, priority and result latching
// Assumes: Comparator and pulse inputs come from analog pins; writes and
//          reads arrive as one-cycle strobes from an on-chip bus slave
// Notes:   Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module sfd_seq
    import sfd_pkg::*;
#(
    parameter int RECHECK_N = RECHECK_CYC,
    parameter int DIAG_N    = DIAG_CYC
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           rstn_i,
    // Instruction writes and result reads
    input  wire logic           wr_stb_i,
    input  wire logic [7:0]     first_instruction_byte_i,
    input  wire logic [7:0]     second_instruction_byte_i,
    input  wire logic           rd_stb_i,
    // Analog comparator pins, per channel
    input  wire logic [NCH-1:0] ovl_i,
    input  wire logic [NCH-1:0] gnd_so_i,
    input  wire logic [NCH-1:0] gnd_sk_i,
    input  wire logic [NCH-1:0] vs_i,
    input  wire logic [NCH-1:0] sl_pa_i,
    input  wire logic [NCH-1:0] sl_ld_i,
    input  wire logic [NCH-1:0] ol_pa_i,
    input  wire logic [NCH-1:0] ol_ld_i,
    input  wire logic [NCH-1:0] offs_i,
    input  wire logic [NCH-1:0] ipk_hi_i,
    // Control outputs
    output logic [NCH-1:0]      ch_off_o,
    output logic                pulse_o,
    output logic                hiz_o,
    output logic                ld_thr_o,
    // Diagnostic bytes
    output logic [7:0]          first_diagnostic_byte_o,
    output logic [7:0]          diag_byte2_o,
    output logic [7:0]          diag_byte3_o,
    output logic [7:0]          diag_byte4_o
);

    // Top-level sequencer states. The spare idle code is never entered by
    // design; it is kept so a corrupted state word has a defined way home.
    // Standby and pulse both keep the power stage at high impedance, so the
    // turn-on pulse never overlaps a biased output.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PULSE = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_STBY  = 4'b1000
    } sfd_top_t;

    // Per-channel overload states: active, waiting for the recheck, or
    // running a permanent diagnostic cycle. Each channel walks on its own,
    // so one shorted output never takes its neighbours down.
    typedef enum logic [2:0] {
        CH_ACT  = 3'b001,
        CH_CHK  = 3'b010,
        CH_DIAG = 3'b100
    } sfd_ch_t;

    // All state but the pin synchronisers in one word: the comb process builds a copy, the flop
    // registers it. Counters are wide enough for the full-length cycle;
    // shorter parameter values simply leave the upper bits at zero.
    typedef struct packed {
        sfd_top_t             st;
        logic [7:0]           ib1;
        logic [7:0]           ib2;
        logic [26:0]          tcnt;
        logic                 armed;
        logic                 done;
        logic [NCH-1:0][5:0]  cur;     // Current cycle result
        logic [NCH-1:0][5:0]  rep;     // Reported previous cycle
        logic [NCH-1:0]       rest;    // Channel in restart mode
        sfd_ch_t [NCH-1:0]    cst;
        logic [NCH-1:0][26:0] ccnt;
        logic [NCH-1:0]       offs_ok;
        logic [NCH-1:0][1:0]  pcnt;
        logic [NCH-1:0]       ipk_q;
        logic [NCH-1:0]       sc_seen;
        logic [NCH-1:0]       off_q;
        logic                 done_rep;
    } sfd_state_t;

    sfd_state_t r_ff;
    sfd_state_t nxt_r;

    // Two-flop synchronisers for all analog pins
    // Comparator levels are asynchronous to the clock; only the second
    // stage is read, so every decision sees a settled value. The cost is
    // two cycles of latency, which the millisecond timing easily absorbs.
    localparam int NSY = 10 * NCH;
    logic [NSY-1:0] sy1_ff;
    logic [NSY-1:0] sy2_ff;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sy1_ff <= '0;
            sy2_ff <= '0;
        end else begin
            sy1_ff <= {ovl_i, gnd_so_i, gnd_sk_i, vs_i, sl_pa_i,
                       sl_ld_i, ol_pa_i, ol_ld_i, offs_i, ipk_hi_i};
            sy2_ff <= sy1_ff;
        end
    end
    logic [NCH-1:0] ovl, gso, gsk, vsh, slp, sll, olp, oll, ofs, ipk;
    assign {ovl, gso, gsk, vsh, slp, sll, olp, oll, ofs, ipk} = sy2_ff;

    // Priority encode one channel's static faults
    // Supply short wins over everything; a source-side ground short with it
    // shows both. Open load is masked in permanent diagnostics because the
    // biased stage cannot tell it from a normal load.
    function automatic logic [5:0] prio_f(input logic so, input logic sk,
                                          input logic v, input logic sl,
                                          input logic ol, input logic perm);
        logic [5:0] f;
        f = '0;
        f[RB_PERM] = perm;
        if (v) begin
            f[RB_SHORT_VS]  = 1'b1;
            f[RB_SHORT_GND] = so;
        end else if (sk && ol && !perm) begin
            f[RB_OPEN_OFFS] = 1'b1;
        end else if (so || sk) begin
            f[RB_SHORT_GND] = 1'b1;
        end else if (sl) begin
            f[RB_SHORT_LOAD] = 1'b1;
        end else if (ol && !perm) begin
            f[RB_OPEN_OFFS] = 1'b1;
        end
        return f;
    endfunction : prio_f

    // Line-driver thresholds: 12 dB gain and line mode selected
    // Both gain bits must be at 12 dB; a mixed setting keeps the amplifier
    // thresholds, which is the safer choice for a low-impedance speaker.
    logic ld_sel;
    assign ld_sel = r_ff.ib1[IB1_GAIN_F] && r_ff.ib1[IB1_GAIN_R]
                    && r_ff.ib2[IB2_LINE_DRV];

    // Enables follow the last written instruction bytes directly
    logic diag_en;
    logic offs_en;
    logic ac_en;
    assign diag_en = r_ff.ib1[IB1_DIAG_EN];
    assign offs_en = r_ff.ib1[IB1_OFFS_EN];
    assign ac_en   = r_ff.ib2[IB2_AC_EN];

    // Next-state logic for sequencer, channels and results
    // Order matters: instruction capture first, then sequencer and channels,
    // and the read last, so a read wins over anything it re-arms.
    always_comb begin
        logic leave_stby;
        logic [5:0] f;
        leave_stby = 1'b0;
        f = '0;
        nxt_r = r_ff;
        if (wr_stb_i) begin
            nxt_r.ib1 = first_instruction_byte_i;
            nxt_r.ib2 = second_instruction_byte_i;
            leave_stby = second_instruction_byte_i[IB2_STBY_OFF]
                         && !r_ff.ib2[IB2_STBY_OFF];
            if (first_instruction_byte_i[IB1_OFFS_EN] && !r_ff.ib1[IB1_OFFS_EN]) begin
                nxt_r.offs_ok = '1;
                nxt_r.sc_seen = '0;
            end
            if (second_instruction_byte_i[IB2_AC_EN] && !r_ff.ib2[IB2_AC_EN]) begin
                nxt_r.pcnt = '0;
                nxt_r.sc_seen = '0;
            end
        end
        // Top sequencer
        // A turn-on pulse needs the arm left by reset or by a read; without
        // it standby is left straight into play so old results survive.
        case (r_ff.st)
            ST_STBY: begin
                if (leave_stby && first_instruction_byte_i[IB1_DIAG_EN]
                    && r_ff.armed) begin
                    nxt_r.st    = ST_PULSE;
                    nxt_r.tcnt  = '0;
                    nxt_r.armed = 1'b0;
                    nxt_r.done  = 1'b0;
                end else if (leave_stby) begin
                    nxt_r.st = ST_RUN;
                end
            end
            ST_PULSE: begin
                nxt_r.tcnt = r_ff.tcnt + 27'd1;
                if (r_ff.tcnt == 27'(DIAG_N - 1)) begin
                    for (int c = 0; c < NCH; c++) begin
                        nxt_r.cur[c] = prio_f(gso[c], gsk[c], vsh[c],
                            ld_sel ? sll[c] : slp[c], ld_sel ? oll[c] : olp[c], 1'b0);
                    end
                    nxt_r.done = 1'b1;
                    nxt_r.st   = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_stb_i && !second_instruction_byte_i[IB2_STBY_OFF]) begin
                    nxt_r.st = ST_STBY;
                end
            end
            ST_IDLE: nxt_r.st = ST_STBY;
            default: nxt_r.st = ST_STBY;
        endcase
        // Per-channel overload handling
        // Window flags for offset and current sensing are updated every cycle;
        // the read stage below turns them into reported bits.
        for (int c = 0; c < NCH; c++) begin
            if (ovl[c]) begin
                nxt_r.sc_seen[c] = 1'b1;
            end
            if (r_ff.offs_ok[c] && !ofs[c]) begin
                nxt_r.offs_ok[c] = 1'b0;
            end
            nxt_r.ipk_q[c] = ipk[c];
            if (ipk[c] && !r_ff.ipk_q[c] && r_ff.pcnt[c] != 2'(AC_MIN_PULSES)) begin
                nxt_r.pcnt[c] = r_ff.pcnt[c] + 2'd1;
            end
            case (r_ff.cst[c])
                CH_ACT: begin
                    if (ovl[c] && r_ff.st == ST_RUN) begin
                        nxt_r.cst[c]  = CH_CHK;
                        nxt_r.ccnt[c] = '0;
                    end
                end
                CH_CHK: begin
                    nxt_r.ccnt[c] = r_ff.ccnt[c] + 27'd1;
                    if (r_ff.ccnt[c] == 27'(RECHECK_N - 1)) begin
                        nxt_r.ccnt[c] = '0;
                        if (!ovl[c]) begin
                            nxt_r.cst[c] = CH_ACT;
                        end else if (diag_en && r_ff.armed && !r_ff.rest[c]) begin
                            nxt_r.cst[c]  = CH_DIAG;
                            nxt_r.armed   = 1'b0;
                            nxt_r.done    = 1'b0;
                        end
                    end
                end
                CH_DIAG: begin
                    nxt_r.ccnt[c] = r_ff.ccnt[c] + 27'd1;
                    if (r_ff.ccnt[c] == 27'(DIAG_N - 1)) begin
                        f = prio_f(gso[c], gsk[c], vsh[c],
                            ld_sel ? sll[c] : slp[c], 1'b0, 1'b1);
                        nxt_r.cur[c]  = f;
                        nxt_r.rest[c] = 1'b1;
                        nxt_r.done    = 1'b1;
                        nxt_r.ccnt[c] = '0;
                        nxt_r.cst[c]  = CH_CHK;
                    end
                end
                default: nxt_r.cst[c] = CH_ACT;
            endcase
        end
        // A read hands over the last cycle and re-arms everything
        if (rd_stb_i) begin
            for (int c = 0; c < NCH; c++) begin
                f = r_ff.cur[c];
                if (offs_en && !f[RB_SHORT_GND] && !f[RB_SHORT_VS]) begin
                    f[RB_OPEN_OFFS] = r_ff.offs_ok[c] && !r_ff.sc_seen[c];
                end
                f[RB_AC_OPEN] = ac_en && !r_ff.sc_seen[c]
                                && r_ff.pcnt[c] != 2'(AC_MIN_PULSES);
                nxt_r.rep[c] = f;
            end
            nxt_r.off_q    = r_ff.offs_ok;
            nxt_r.done_rep = r_ff.done;
            nxt_r.armed    = 1'b1;
            nxt_r.offs_ok  = '1;
            // A pin event in the read cycle opens the new window, so the
            // clear never swallows an overload or a current pulse edge
            for (int c = 0; c < NCH; c++) begin
                nxt_r.pcnt[c] = {1'b0, ipk[c] && !r_ff.ipk_q[c]};
            end
            nxt_r.sc_seen  = ovl;
            // A channel finishing its cycle on this edge keeps its flag
            nxt_r.rest     = nxt_r.rest & ~r_ff.rest;
        end
    end

    // State register
    // Reset leaves the block in standby and armed, so the first write that
    // leaves standby with diagnostics enabled gets its turn-on pulse.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_ff          <= '0;
            r_ff.st       <= ST_STBY;
            r_ff.ib1      <= IB_RST;
            r_ff.ib2      <= IB_RST;
            r_ff.armed    <= 1'b1;
            for (int c = 0; c < NCH; c++) begin
                r_ff.cst[c] <= CH_ACT;
            end
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs
    // All outputs decode registered state only, so they never glitch on a
    // strobe. Result bits change solely on the edge after a read; the enable and standby status bits change on the edge after a write.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ch_off_o[c] = r_ff.cst[c] != CH_ACT;
        end
    end
    assign pulse_o  = r_ff.st == ST_PULSE;
    assign hiz_o    = r_ff.st != ST_RUN;
    assign ld_thr_o = ld_sel;
    assign first_diagnostic_byte_o = {1'b0, r_ff.done_rep, r_ff.rep[0]};
    assign diag_byte2_o = {offs_en, ac_en, r_ff.rep[1]};
    assign diag_byte3_o = {r_ff.ib2[IB2_STBY_OFF], diag_en, r_ff.rep[2]};
    assign diag_byte4_o = {2'b00, r_ff.rep[3]};

endmodule : sfd_seq

//--- testbench/sfd_seq_properties.sv
// Purpose: Port-level properties of the diagnostic sequencer
// Assumes: Shortened counts handed in by the bind
// Notes:   Status bits judged only once writes have settled
`timescale 1ns/1ps
module sfd_seq_chk
    import sfd_pkg::*;
#(
    parameter int RECHECK_N = 10,
    parameter int DIAG_N    = 50
) (
    // Watched ports
    input wire logic           clk_i,
    input wire logic           rstn_i,
    input wire logic           wr_stb_i,
    input wire logic [7:0]     first_instruction_byte_i,
    input wire logic [7:0]     second_instruction_byte_i,
    input wire logic           rd_stb_i,
    input wire logic [NCH-1:0] ovl_i,
    input wire logic [NCH-1:0] ch_off_o,
    input wire logic           pulse_o,
    input wire logic           hiz_o,
    input wire logic           ld_thr_o,
    input wire logic [7:0]     first_diagnostic_byte_o,
    input wire logic [7:0]     diag_byte2_o,
    input wire logic [7:0]     diag_byte3_o,
    input wire logic [7:0]     diag_byte4_o
);
    logic [7:0] ib1_ff;
    logic [7:0] ib2_ff;
    int         plen_ff;
    // Last written bytes and running pulse length
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ib1_ff  <= 8'h00;
            ib2_ff  <= 8'h00;
            plen_ff <= 0;
        end else begin
            if (wr_stb_i) begin
                ib1_ff <= first_instruction_byte_i;
                ib2_ff <= second_instruction_byte_i;
            end
            plen_ff <= pulse_o ? plen_ff + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Three idle cycles give any write latency time to land
    sequence s_quiet;
        !wr_stb_i [*3];
    endsequence
    a_pulse_cause: assert property ($rose(pulse_o) |-> $past(wr_stb_i) || $past(wr_stb_i, 2))
        else $error("test pulse started without a write");
    a_pulse_hiz: assert property (pulse_o |-> hiz_o)
        else $error("outputs driven during test pulse");
    a_pulse_len: assert property ($fell(pulse_o) |-> plen_ff == DIAG_N)
        else $error("test pulse length wrong");
    a_ld_thr: assert property (s_quiet |-> ld_thr_o == (ib1_ff[IB1_GAIN_F]
        && ib1_ff[IB1_GAIN_R] && ib2_ff[IB2_LINE_DRV])) else $error("threshold set wrong");
    a_diag_status: assert property (s_quiet |-> diag_byte3_o[6] == ib1_ff[IB1_DIAG_EN]
        && diag_byte2_o[7] == ib1_ff[IB1_OFFS_EN]) else $error("enable status bits wrong");
    a_ac_status: assert property (s_quiet |-> diag_byte2_o[6] == ib2_ff[IB2_AC_EN])
        else $error("current sensor status wrong");
    a_done_read: assert property ($rose(first_diagnostic_byte_o[FB1_DONE])
        |-> $past(rd_stb_i) || $past(rd_stb_i, 2)) else $error("done bit rose without read");
    a_bytes_hold: assert property (!$past(rd_stb_i) && !$past(rd_stb_i, 2)
        |-> $stable(diag_byte4_o[5:0])) else $error("result byte changed without read");
    a_off_rise: assert property ($rose(ovl_i[2]) |-> ##[1:4] ch_off_o[2])
        else $error("overloaded channel not shut down");
    a_off_cause: assert property ($rose(ch_off_o[2]) |-> $past(ovl_i[2], 2)
        || $past(ovl_i[2], 3) || $past(ovl_i[2], 4)) else $error("channel shut without overload");
    c_pulse: cover property ($rose(pulse_o));
    c_off: cover property ($rose(ch_off_o[2]));
    c_done: cover property ($rose(first_diagnostic_byte_o[FB1_DONE]));
endmodule : sfd_seq_chk

bind sfd_seq sfd_seq_chk #(.RECHECK_N(RECHECK_N), .DIAG_N(DIAG_N)) i_sfd_seq_chk (.*);

//--- testbench/sfd_uc_model.sv
// Purpose: Controller side issuing instruction writes and result reads
// Assumes: One-cycle strobes launched just after a rising edge
// Notes:   Bytes are scrambled after each write so stale values show up
`timescale 1ns/1ps
module sfd_uc_model (
    // Clock and strobes
    input  wire logic  clk_i,
    output logic       wr_stb_o,
    output logic [7:0] ib1_o,
    output logic [7:0] ib2_o,
    output logic       rd_stb_o
);
    initial begin
        wr_stb_o = 1'b0;
        rd_stb_o = 1'b0;
        ib1_o    = 8'h00;
        ib2_o    = 8'h00;
    end
    // Write both bytes in one strobe, then no longer hold them
    task automatic write_bytes(input logic [7:0] b1, input logic [7:0] b2);
        @(posedge clk_i);
        wr_stb_o <= 1'b1;
        ib1_o    <= b1;
        ib2_o    <= b2;
        @(posedge clk_i);
        wr_stb_o <= 1'b0;
        ib1_o    <= ~b1;
        ib2_o    <= ~b2;
    endtask : write_bytes
    // Poll spacing is left to the caller
    task automatic read_bytes();
        @(posedge clk_i);
        rd_stb_o <= 1'b1;
        @(posedge clk_i);
        rd_stb_o <= 1'b0;
    endtask : read_bytes
endmodule : sfd_uc_model

//--- testbench/speaker_fault_diagnostic_sequencer_tb_top.sv
// Purpose: Self-checking bench for the diagnostic sequencer
// Assumes: Shortened recheck and cycle counts
// Notes:   Pins move in groups so every fault pattern is stable
`timescale 1ns/1ps
module speaker_fault_diagnostic_sequencer_tb_top
    import sfd_pkg::*;
;
    localparam int RN = 10;
    localparam int DN = 50;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wr, rd;
    logic [7:0] ib1, ib2, b1, b2, b3, b4;
    logic [NCH-1:0] ovl_i = '0, gso = '0, gsk = '0, vs = '0, olp = '0, offs = '0, ipk = '0;
    logic [NCH-1:0] ch_off;
    logic pulse, hiz, ld;
    int errors = 0;
    int total_checks = 0;
    int n;
    always #2 clk_i = ~clk_i;
    sfd_uc_model i_sfd_uc_model (.clk_i(clk_i), .wr_stb_o(wr), .ib1_o(ib1), .ib2_o(ib2),
        .rd_stb_o(rd));
    sfd_seq #(.RECHECK_N(RN), .DIAG_N(DN)) i_sfd_seq (.clk_i(clk_i), .rstn_i(rstn_i),
        .wr_stb_i(wr), .first_instruction_byte_i(ib1), .second_instruction_byte_i(ib2),
        .rd_stb_i(rd), .ovl_i(ovl_i), .gnd_so_i(gso), .gnd_sk_i(gsk), .vs_i(vs),
        .sl_pa_i('0), .sl_ld_i('0), .ol_pa_i(olp), .ol_ld_i('0), .offs_i(offs),
        .ipk_hi_i(ipk), .ch_off_o(ch_off), .pulse_o(pulse), .hiz_o(hiz), .ld_thr_o(ld),
        .first_diagnostic_byte_o(b1), .diag_byte2_o(b2), .diag_byte3_o(b3), .diag_byte4_o(b4));
    // Wait edges, then let their updates settle
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic t_turn_on();
        gsk <= 4'h2; vs <= 4'hC; gso <= 4'h4; olp <= 4'hB;
        cyc(4);
        i_sfd_uc_model.write_bytes(8'h40, 8'h10);
        n = 0;
        while (pulse !== 1'b1 && n < 4) begin cyc(1); n++; end
        chk("hiz in pulse", 8'h01, {7'h0, hiz});
        n = 1; // First high cycle passed before the loop above sampled it
        while (pulse === 1'b1 && n < DN + 10) begin cyc(1); n++; end
        chk("pulse length", 8'(DN), 8'(n));
        i_sfd_uc_model.write_bytes(8'h40, 8'h00);
        i_sfd_uc_model.write_bytes(8'h40, 8'h10);
        cyc(6);
        chk("pulse without read", 8'h00, {7'h0, pulse});
        i_sfd_uc_model.read_bytes();
        cyc(3);
        chk("db1", 8'h44, b1 & 8'h5F);
        chk("db2", 8'h04, b2 & 8'h1F);
        chk("db3", 8'h03, b3 & 8'h1F);
        chk("db4", 8'h02, b4 & 8'h1F);
        gsk <= '0; vs <= '0; gso <= '0; olp <= '0;
        $display("turn-on test done");
    endtask : t_turn_on
    task automatic t_restart();
        i_sfd_uc_model.write_bytes(8'h18, 8'h18);
        cyc(2);
        chk("line thresholds", 8'h01, {7'h0, ld});
        i_sfd_uc_model.write_bytes(8'h00, 8'h10);
        ovl_i <= 4'h4;
        cyc(6);
        chk("only faulted off", 8'h04, {4'h0, ch_off});
        ovl_i <= 4'h0;
        cyc(2 * RN + 8);
        chk("restarted", 8'h00, {4'h0, ch_off});
        $display("restart test done");
    endtask : t_restart
    task automatic t_permanent();
        i_sfd_uc_model.write_bytes(8'h40, 8'h10);
        i_sfd_uc_model.read_bytes();
        ovl_i <= 4'h2;
        cyc(2);
        ovl_i <= 4'h0;
        cyc(RN + 10);
        chk("spike ignored", 8'h00, {4'h0, ch_off});
        ovl_i <= 4'h1; vs <= 4'h1; olp <= 4'h1;
        cyc(RN + DN + 20);
        i_sfd_uc_model.read_bytes();
        cyc(3);
        chk("permanent db1", 8'h12, b1 & 8'h1F);
        ovl_i <= '0; vs <= '0; olp <= '0;
        $display("permanent test done");
    endtask : t_permanent
    task automatic t_offset_ac();
        offs <= 4'h2;
        i_sfd_uc_model.write_bytes(8'h60, 8'h14);
        cyc(4);
        chk("enables", 8'h07, {5'h0, b2[7:6], b3[6]});
        // Tone of three peaks on one channel per window
        repeat (3) begin
            repeat (3) begin ipk <= 4'h8; cyc(2); ipk <= '0; cyc(2); end
            cyc(4);
            i_sfd_uc_model.read_bytes();
            cyc(2);
        end
        chk("offset ch1", 8'h04, b2 & 8'h04);
        chk("open tweeter", 8'h0E, {4'h0, b1[5], b2[5], b3[5], b4[5]});
        offs <= '0;
        cyc(4);
        i_sfd_uc_model.read_bytes();
        cyc(3);
        chk("offset dropped", 8'h00, b2 & 8'h04);
        $display("offset and ac test done");
    endtask : t_offset_ac
    initial begin
        cyc(10);
        chk("reset", 8'h00, {4'h0, ch_off} | b1 | b2 | b4); // [RESET]
        chk("reset hiz", 8'h03, {6'h0, hiz, ~pulse}); // [RESET]
        rstn_i <= 1'b1;
        t_turn_on();
        t_restart();
        t_permanent();
        t_offset_ac();
        give_verdict();
    end
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        give_verdict();
    end
endmodule : speaker_fault_diagnostic_sequencer_tb_top
